// ### common/pin_select_pkg.sv
// constants, register map and channel table of the remappable input pin select
// ============================================================================
// Operation
// - twenty-seven remap registers: fourteen input, thirteen output
// - remap registers change only while lock is zero
// - unimplemented input selector bits ignore writes, read zero
// - implemented input selector bits read/write, reset ones
// - bits 12:8 of register one steer irq one
// - bits 4:0 of register two steer irq two
// - timer two/three clock pins in one register
// - timer four/five clock pins in one register
// - capture one/two pins in one register
// - capture three/four pins in one register
// - capture five pin in bits 4:0 only
// - compare fault a low field, b high field
// - port one receive low, clear-to-send high
// - port two receive low, clear-to-send high
// - locked writes complete without error, change nothing
// - one-way config forbids clearing a set lock
// - lock comes out of reset unlocked
`default_nettype none
package pin_select_pkg;
  // ==========================================================================
  // register map (word indices, byte address is four times the index)
  localparam int unsigned IN_REG_COUNT = 14; // input selector registers
  localparam int unsigned OUT_REG_COUNT = 13; // output selector registers
  localparam logic [5:0] IN_BASE_IDX = 6'h00; // first input selector word
  localparam logic [5:0] OUT_BASE_IDX = 6'h10; // first output selector word
  localparam logic [5:0] OSC_IDX = 6'h20; // oscillator control register word
  localparam int unsigned WORD_IDX_W = 6; // word index width
  // ==========================================================================
  // field layout
  localparam int unsigned FIELD_W = 5; // selector field width
  localparam int unsigned HI_LSB = 8; // high field lowest bit
  localparam int unsigned LO_LSB = 0; // low field lowest bit
  localparam int unsigned LOCK_BIT = 6; // lock position in oscillator control
  localparam logic [FIELD_W-1:0] IN_SEL_RESET = 5'h1F; // input selectors reset
  localparam logic [FIELD_W-1:0] OUT_SEL_RESET = 5'h00; // output selectors reset
  // per input register: which fields exist (bit = register index)
  localparam logic [IN_REG_COUNT-1:0] IN_HI_PRESENT = 14'h17BD; // high fields
  localparam logic [IN_REG_COUNT-1:0] IN_LO_PRESENT = 14'h3FFE; // low fields
  // ==========================================================================
  // unlock keys written to the low byte of oscillator control
  localparam logic [7:0] UNLOCK_KEY_ONE = 8'h46; // first key
  localparam logic [7:0] UNLOCK_KEY_TWO = 8'h57; // second key
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_ONE_SEEN,
    KEY_TWO_SEEN
  } unlock_state_t;
  // ==========================================================================
  // peripheral input channels: owning register and field (1 = high field)
  localparam int unsigned CHAN_COUNT = 17; // routed peripheral inputs
  localparam logic [CHAN_COUNT-1:0][3:0] CHAN_REG = {
    4'h9, 4'h9, 4'h8, 4'h8, 4'h7, 4'h7, 4'h6, 4'h5, 4'h5,
    4'h4, 4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0
  };
  localparam logic [CHAN_COUNT-1:0] CHAN_HI = 17'h1_52A9; // field select
endpackage : pin_select_pkg
`default_nettype wire

// ### rtl/pin_select_mux.sv
// one peripheral input picked from the remappable pins by a selector field
`default_nettype none
module pin_select_mux #(
  parameter int unsigned PIN_COUNT = 32, // selectable pin numbers
  parameter logic [31:0] PIN_PRESENT = 32'h7FFF_FFFF // pins on this device
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [pin_select_pkg::FIELD_W-1:0] sel_i, // selector field
  input wire logic [PIN_COUNT-1:0] pin_i, // remappable pin levels
  output logic level_o // registered peripheral input
);
  import pin_select_pkg::*;

  // ==========================================================================
  // elaboration check: five-bit selector addresses exactly 32 pins
  if (PIN_COUNT != 32) begin : g_bad_count
    $error("pin_select_mux: PIN_COUNT must be 32");
  end

  typedef struct packed {
    logic level; // sampled pin level
  } mux_state_t;

  mux_state_t st_q; // state register
  mux_state_t st_d; // next state

  // ==========================================================================
  // pick the pin; an absent pin gives a low level
  always_comb begin
    st_d = st_q;
    st_d.level = PIN_PRESENT[sel_i] & pin_i[sel_i];
  end

  // register the level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;
endmodule // pin_select_mux
`default_nettype wire

// ### rtl/pin_select_lock.sv
// remap lock bit with its two-key unlock sequence and one-way option
`default_nettype none
module pin_select_lock (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wr_i, // completed write to oscillator control, low byte
  input wire logic [7:0] wdata_i, // written low byte
  input wire logic one_way_i, // one-way remap configuration
  output logic lock_o // remap lock level
);
  import pin_select_pkg::*;

  typedef struct packed {
    unlock_state_t seq; // key progress
    logic lock; // remap lock
  } lock_state_t;

  lock_state_t st_q; // state register
  lock_state_t st_d; // next state

  // ==========================================================================
  // key sequence: 46h, 57h, then one write that sets or clears the lock
  always_comb begin
    st_d = st_q;
    if (wr_i) begin
      case (st_q.seq)
        KEY_IDLE: begin
          st_d.seq = (wdata_i == UNLOCK_KEY_ONE) ? KEY_ONE_SEEN : KEY_IDLE;
        end
        KEY_ONE_SEEN: begin
          // a wrong second key restarts, but may itself be a first key
          if (wdata_i == UNLOCK_KEY_TWO) begin
            st_d.seq = KEY_TWO_SEEN;
          end else if (wdata_i == UNLOCK_KEY_ONE) begin
            st_d.seq = KEY_ONE_SEEN;
          end else begin
            st_d.seq = KEY_IDLE;
          end
        end
        KEY_TWO_SEEN: begin
          st_d.seq = KEY_IDLE;
          // one-way mode lets a set lock stay set until reset
          if (!(one_way_i && st_q.lock)) begin
            st_d.lock = wdata_i[LOCK_BIT];
          end
        end
        default: begin
          st_d.seq = KEY_IDLE;
        end
      endcase
    end
  end

  // register state; lock leaves reset unlocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.seq <= KEY_IDLE;
      st_q.lock <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lock_o = st_q.lock;
endmodule // pin_select_lock
`default_nettype wire

// ### rtl/remappable_input_pin_select.sv
// apb register file and input routing of the remappable pin select block
//
// Chosen here: register access over APB and the register addresses.
`default_nettype none
module remappable_input_pin_select #(
  parameter int unsigned ADDR_W = 8, // apb byte address width
  parameter logic [31:0] PIN_PRESENT = 32'h7FFF_FFFF // pins on this device
) (
  input wire logic clk_i, // core clock, 100 MHz
  input wire logic rst_i, // synchronous reset, high
  // apb slave
  input wire logic psel_i, // select
  input wire logic penable_i, // access phase
  input wire logic pwrite_i, // write when high
  input wire logic [ADDR_W-1:0] paddr_i, // byte address
  input wire logic [31:0] pwdata_i, // write data
  input wire logic [3:0] pstrb_i, // write byte enables
  output logic [31:0] prdata_o, // read data
  output logic pready_o, // transfer done
  output logic pslverr_o, // unmapped address
  // configuration and status
  input wire logic one_way_remap_config_i, // one-way lock option
  output logic remap_lock_o, // lock level
  // pins
  input wire logic [31:0] remappable_pin_i, // remappable pin levels
  // peripheral inputs
  output logic external_irq_one_o, // irq one input
  output logic external_irq_two_o, // irq two input
  output logic timer_two_ext_clock_o, // timer two clock
  output logic timer_three_ext_clock_o, // timer three clock
  output logic timer_four_ext_clock_o, // timer four clock
  output logic timer_five_ext_clock_o, // timer five clock
  output logic capture_channel_one_o, // capture one
  output logic capture_channel_two_o, // capture two
  output logic capture_channel_three_o, // capture three
  output logic capture_channel_four_o, // capture four
  output logic capture_channel_five_o, // capture five
  output logic compare_fault_a_o, // compare fault a
  output logic compare_fault_b_o, // compare fault b
  output logic port_one_receive_o, // port one receive
  output logic port_one_clear_to_send_o, // port one cts
  output logic port_two_receive_o, // port two receive
  output logic port_two_clear_to_send_o // port two cts
);
  import pin_select_pkg::*;

  // ==========================================================================
  // elaboration check
  if (ADDR_W < WORD_IDX_W + 2) begin : g_bad_addr
    $error("remappable_input_pin_select: ADDR_W too small for the map");
  end

  // ==========================================================================
  // state
  typedef logic [1:0][FIELD_W-1:0] sel_pair_t; // [1]=high field, [0]=low

  typedef struct packed {
    logic [IN_REG_COUNT-1:0][1:0][FIELD_W-1:0] in_sel; // input selectors
    logic [OUT_REG_COUNT-1:0][1:0][FIELD_W-1:0] out_sel; // output selectors
    logic ready; // access answered
    logic err; // error answer
    logic [31:0] rdata; // read data
  } regs_state_t;

  regs_state_t st_q; // state register
  regs_state_t st_d; // next state

  logic remap_lock; // lock from the key sequencer
  logic osc_wr; // completed write to oscillator control low byte
  logic [CHAN_COUNT-1:0] chan_level; // registered peripheral levels

  // decode helpers
  logic [WORD_IDX_W-1:0] word_idx; // word index of the access
  logic hit_in; // input selector word
  logic hit_out; // output selector word
  logic hit_osc; // oscillator control word
  logic [3:0] in_k; // input register number
  logic [3:0] out_k; // output register number
  logic acc_end; // edge where the transfer completes

  // ==========================================================================
  // address decode
  always_comb begin
    word_idx = paddr_i[WORD_IDX_W+1:2];
    in_k = 4'(word_idx - IN_BASE_IDX);
    out_k = 4'(word_idx - OUT_BASE_IDX);
    hit_in = (paddr_i[1:0] == 2'h0) && (word_idx >= IN_BASE_IDX)
      && (word_idx < IN_BASE_IDX + 6'(IN_REG_COUNT));
    hit_out = (paddr_i[1:0] == 2'h0) && (word_idx >= OUT_BASE_IDX)
      && (word_idx < OUT_BASE_IDX + 6'(OUT_REG_COUNT));
    hit_osc = (paddr_i[1:0] == 2'h0) && (word_idx == OSC_IDX);
    // high address bits beyond the map must be zero
    if (ADDR_W > WORD_IDX_W + 2) begin
      if ((paddr_i >> (WORD_IDX_W + 2)) != '0) begin
        hit_in = 1'b0;
        hit_out = 1'b0;
        hit_osc = 1'b0;
      end
    end
    acc_end = psel_i && penable_i && st_q.ready;
  end

  // oscillator control low byte write, seen by the key sequencer
  assign osc_wr = acc_end && pwrite_i && hit_osc && pstrb_i[0];

  // ==========================================================================
  // lock bit and its key sequence
  pin_select_lock u_lock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(osc_wr),
    .wdata_i(pwdata_i[7:0]),
    .one_way_i(one_way_remap_config_i),
    .lock_o(remap_lock)
  );

  // ==========================================================================
  // read value of an input selector word, absent fields as zero
  function automatic logic [31:0] in_word(input sel_pair_t v, input logic hi, input logic lo);
    logic [31:0] w;
    w = '0;
    if (hi) begin
      w[HI_LSB +: FIELD_W] = v[1];
    end
    if (lo) begin
      w[LO_LSB +: FIELD_W] = v[0];
    end
    return w;
  endfunction

  // ==========================================================================
  // apb slave: one wait cycle, then pready with data and error
  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b0;
    st_d.err = 1'b0;
    // first access cycle: build the answer for the next edge
    if (psel_i && penable_i && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.err = !(hit_in || hit_out || hit_osc);
      st_d.rdata = '0;
      if (!pwrite_i) begin
        if (hit_in) begin
          st_d.rdata = in_word(st_q.in_sel[in_k], IN_HI_PRESENT[in_k], IN_LO_PRESENT[in_k]);
        end else if (hit_out) begin
          st_d.rdata[HI_LSB +: FIELD_W] = st_q.out_sel[out_k][1];
          st_d.rdata[LO_LSB +: FIELD_W] = st_q.out_sel[out_k][0];
        end else if (hit_osc) begin
          st_d.rdata[LOCK_BIT] = remap_lock;
        end
      end
    end
    // completing write: selectors change only while unlocked
    // a locked write still completes normally, with no error
    if (acc_end && pwrite_i && !remap_lock) begin
      if (hit_in) begin
        // absent fields are never stored, so they keep reading zero
        if (pstrb_i[1] && IN_HI_PRESENT[in_k]) begin
          st_d.in_sel[in_k][1] = pwdata_i[HI_LSB +: FIELD_W];
        end
        if (pstrb_i[0] && IN_LO_PRESENT[in_k]) begin
          st_d.in_sel[in_k][0] = pwdata_i[LO_LSB +: FIELD_W];
        end
      end else if (hit_out) begin
        if (pstrb_i[1]) begin
          st_d.out_sel[out_k][1] = pwdata_i[HI_LSB +: FIELD_W];
        end
        if (pstrb_i[0]) begin
          st_d.out_sel[out_k][0] = pwdata_i[LO_LSB +: FIELD_W];
        end
      end
    end
  end

  // register state; input selectors reset to all ones, outputs to null
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.in_sel <= {(IN_REG_COUNT * 2){IN_SEL_RESET}};
      st_q.out_sel <= {(OUT_REG_COUNT * 2){OUT_SEL_RESET}};
      st_q.ready <= 1'b0;
      st_q.err <= 1'b0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o = st_q.rdata;
  assign pready_o = st_q.ready;
  assign pslverr_o = st_q.err;

  // ==========================================================================
  // lock status straight from the sequencer flip-flop
  assign remap_lock_o = remap_lock;

  // ==========================================================================
  // one registered multiplexer per peripheral input
  for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_chan
    pin_select_mux #(
      .PIN_COUNT(32),
      .PIN_PRESENT(PIN_PRESENT)
    ) u_mux (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(st_q.in_sel[CHAN_REG[c]][CHAN_HI[c]]),
      .pin_i(remappable_pin_i),
      .level_o(chan_level[c])
    );
  end

  // ==========================================================================
  // peripheral input ports in channel order
  assign external_irq_one_o = chan_level[0];
  assign external_irq_two_o = chan_level[1];
  assign timer_two_ext_clock_o = chan_level[2];
  assign timer_three_ext_clock_o = chan_level[3];
  assign timer_four_ext_clock_o = chan_level[4];
  assign timer_five_ext_clock_o = chan_level[5];
  assign capture_channel_one_o = chan_level[6];
  assign capture_channel_two_o = chan_level[7];
  assign capture_channel_three_o = chan_level[8];
  assign capture_channel_four_o = chan_level[9];
  assign capture_channel_five_o = chan_level[10];
  assign compare_fault_a_o = chan_level[11];
  assign compare_fault_b_o = chan_level[12];
  assign port_one_receive_o = chan_level[13];
  assign port_one_clear_to_send_o = chan_level[14];
  assign port_two_receive_o = chan_level[15];
  assign port_two_clear_to_send_o = chan_level[16];
endmodule // remappable_input_pin_select
`default_nettype wire

// ### verification/pin_source_model.sv
// model of the remappable device pins that feed the block
`default_nettype none
module pin_source_model (
  input wire logic clk_i, // core clock
  input wire logic load_i, // take new pin levels
  input wire logic [31:0] level_i, // levels to present next
  output logic [31:0] pin_o // pin levels seen by the block
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start high so an absent pin that reads high is caught
  logic [31:0] lv_q = 32'hFFFF_FFFF; // held pin levels
  // pins move just after an edge, like any synchronous source
  always @(posedge clk_i) begin
    if (load_i) begin
      lv_q <= level_i;
    end
  end
  assign pin_o = lv_q;
endmodule // pin_source_model
`default_nettype wire

// ### verification/remappable_input_pin_select_chk.sv
// port assertions of the remappable input pin select
`default_nettype none
module pin_select_chk #(
  parameter int unsigned ADDR_W = 8 // apb byte address width
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic psel_i, // select
  input wire logic penable_i, // access phase
  input wire logic pwrite_i, // write
  input wire logic [ADDR_W-1:0] paddr_i, // byte address
  input wire logic [3:0] pstrb_i, // byte enables
  input wire logic [31:0] prdata_o, // read data
  input wire logic pready_o, // transfer done
  input wire logic pslverr_o, // error
  input wire logic one_way_remap_config_i, // one-way option
  input wire logic remap_lock_o // lock level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] a8; // low address byte
  logic mapped; // address names a register
  logic osc_wr; // completing low-byte write to oscillator control
  assign a8 = paddr_i[7:0];
  assign mapped = a8[1:0] == 2'h0 && (a8 < 8'h38 || (a8 >= 8'h40 && a8 < 8'h74) || a8 == 8'h80);
  assign osc_wr = pready_o && pwrite_i && a8 == 8'h80 && pstrb_i[0];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // apb phases
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && !pready_o;
  endsequence
  // ==========================================================================
  // bus answer
  a_ready_one_wait: assert property (setup_s ##1 access_s |=> pready_o)
    else $error("pready missing one cycle into access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("pslverr wrong for this address");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr outside a completing cycle");
  // ==========================================================================
  // remap lock
  a_lock_from_reset: assert property ($fell(rst_i) |-> !remap_lock_o)
    else $error("lock set after reset");
  a_lock_write_only: assert property ($changed(remap_lock_o) |-> $past(osc_wr))
    else $error("lock moved without a control write");
  a_one_way_hold: assert property (one_way_remap_config_i && remap_lock_o |=> remap_lock_o)
    else $error("one-way lock cleared");
  a_read_lock_bit: assert property (pready_o && !pwrite_i && a8 == 8'h80 |-> prdata_o == {25'h0, remap_lock_o, 6'h0})
    else $error("control read does not show lock");
  a_unimpl_zero: assert property (pready_o && !pwrite_i && mapped && a8 < 8'h80 |->
    prdata_o[31:13] == 19'h0 && prdata_o[7:5] == 3'h0)
    else $error("unimplemented selector bits read nonzero");
endmodule // pin_select_chk
bind remappable_input_pin_select pin_select_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .one_way_remap_config_i(one_way_remap_config_i), .remap_lock_o(remap_lock_o));
`default_nettype wire

// ### verification/remappable_input_pin_select_tb.sv
// self-checking bench of the remappable input pin select
`default_nettype none
module remappable_input_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_select_pkg::*;
  localparam logic [31:0] PRESENT = 32'h7FFF_FFFF; // pin 31 absent
  logic clk_i = 1'b0; // core clock
  logic rst_i = 1'b1; // reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [7:0] paddr = 8'h00; // byte address
  logic [31:0] pwdata = 32'h0000_0000; // write data
  logic [3:0] pstrb = 4'h0; // byte enables
  logic [31:0] prdata, rd_v; // read data, last taken
  logic pready, pslverr, er_v, lock; // answer, last error, lock
  logic one_way = 1'b0; // one-way option
  logic load = 1'b0; // pin model load
  logic [31:0] lvl = 32'h0000_0000; // next pin levels
  logic [31:0] pins; // pin levels
  logic [16:0] outs; // peripheral inputs in channel order
  logic [31:0] sel_m [IN_REG_COUNT]; // expected selector words
  logic [31:0] seed = 32'h0000_2E40; // xorshift state
  logic [3:0] s_v; // random byte enables
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  remappable_input_pin_select #(.ADDR_W(8), .PIN_PRESENT(PRESENT)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .one_way_remap_config_i(one_way), .remap_lock_o(lock), .remappable_pin_i(pins),
    .external_irq_one_o(outs[0]), .external_irq_two_o(outs[1]), .timer_two_ext_clock_o(outs[2]),
    .timer_three_ext_clock_o(outs[3]), .timer_four_ext_clock_o(outs[4]), .timer_five_ext_clock_o(outs[5]),
    .capture_channel_one_o(outs[6]), .capture_channel_two_o(outs[7]), .capture_channel_three_o(outs[8]),
    .capture_channel_four_o(outs[9]), .capture_channel_five_o(outs[10]), .compare_fault_a_o(outs[11]),
    .compare_fault_b_o(outs[12]), .port_one_receive_o(outs[13]), .port_one_clear_to_send_o(outs[14]),
    .port_two_receive_o(outs[15]), .port_two_clear_to_send_o(outs[16]));
  pin_source_model u_pins (.clk_i(clk_i), .load_i(load), .level_i(lvl), .pin_o(pins));
  // next random word
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // selector word after a write: only present fields with enabled bytes move
  function automatic logic [31:0] merge(input int k, input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    if (s[1] && IN_HI_PRESENT[k]) r[12:8] = d[12:8];
    if (s[0] && IN_LO_PRESENT[k]) r[4:0] = d[4:0];
    return r;
  endfunction
  // level a channel should show: selected pin, low when absent
  function automatic logic exp_out(input int c);
    logic [4:0] f;
    f = CHAN_HI[c] ? sel_m[CHAN_REG[c]][12:8] : sel_m[CHAN_REG[c]][4:0];
    return pins[f] & PRESENT[f];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1'b1;
    // read just after an edge, outputs still hold what that edge sampled
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(n, e, rd_v);
    chk("rd_err", 32'h0, {31'h0, er_v});
  endtask
  // two keys, then the lock value in bit 6
  task automatic lock_seq(input logic [7:0] v);
    apb(1'b1, 8'h80, 32'h0000_0046, 4'h1);
    apb(1'b1, 8'h80, 32'h0000_0057, 4'h1);
    apb(1'b1, 8'h80, {24'h0, v}, 4'h1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // runaway guard: the sequence needs under 3000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < IN_REG_COUNT; k++) begin
      sel_m[k] = (IN_HI_PRESENT[k] ? 32'h0000_1F00 : 32'h0) | (IN_LO_PRESENT[k] ? 32'h0000_001F : 32'h0);
      rdc("in_reset", 8'(4 * k), sel_m[k]);
    end
    for (int k = 0; k < OUT_REG_COUNT; k++) rdc("out_reset", 8'(64 + 4 * k), 32'h0);
    chk("lock_reset", 32'h0, {31'h0, lock});
    chk("outs_absent", 32'h0, {15'h0, outs});
    apb(1'b0, 8'h38, 32'h0, 4'h0);
    chk("err_unmapped", 32'h1, {31'h0, er_v});
    apb(1'b1, 8'h06, 32'hFFFF_FFFF, 4'hF);
    chk("err_misaligned", 32'h1, {31'h0, er_v});
    rdc("in_untouched", 8'h04, sel_m[1]);
    $display("test reset_map done");
    for (int it = 0; it < 12; it++) begin
      for (int k = 0; k < 10; k++) begin
        seed = xs(seed);
        s_v = seed[24] ? 4'hF : seed[27:24];
        apb(1'b1, 8'(4 * k), seed, s_v);
        sel_m[k] = merge(k, sel_m[k], seed, s_v);
      end
      seed = xs(seed);
      lvl <= seed;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      for (int c = 0; c < CHAN_COUNT; c++) begin
        chk("route", 32'(exp_out(c)), 32'(outs[c]));
      end
      for (int k = 0; k < 10; k++) rdc("in_readback", 8'(4 * k), sel_m[k]);
    end
    $display("test random_route done");
    lock_seq(8'h40);
    rdc("lock_on", 8'h80, 32'h0000_0040);
    apb(1'b1, 8'h00, 32'h0000_0000, 4'hF);
    chk("locked_err", 32'h0, {31'h0, er_v});
    rdc("locked_in", 8'h00, sel_m[0]);
    apb(1'b1, 8'h40, 32'h0000_1F1F, 4'hF);
    rdc("locked_out", 8'h40, 32'h0);
    apb(1'b1, 8'h80, 32'h0000_0000, 4'h1);
    rdc("no_keys", 8'h80, 32'h0000_0040);
    lock_seq(8'h00);
    rdc("lock_off", 8'h80, 32'h0);
    one_way <= 1'b1;
    lock_seq(8'h40);
    lock_seq(8'h00);
    rdc("one_way", 8'h80, 32'h0000_0040);
    $display("test lock done");
    rst_i <= 1'b1;
    one_way <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("lock_rereset", 32'h0, {31'h0, lock});
    rdc("in_rereset", 8'h08, 32'h0000_1F1F);
    chk("outs_rereset", 32'h0, {15'h0, outs});
    $display("test second_reset done");
    report_and_stop();
  end
endmodule // remappable_input_pin_select_tb
`default_nettype wire
